//--- shared/dram_ctrl_pkg.sv
// Package: constants and carrier types for the dynamic RAM controller
package dram_ctrl_pkg;

  // ==========================================================
  // Address geometry
  localparam int ADDR_W     = 14;
  localparam int ROW_W      = 7;
  localparam int COL_W      = 7;
  localparam int ROW_COUNT  = 128;
  localparam int ROW_LSB    = 7;

  // ==========================================================
  // Timing
  localparam int CLK_PERIOD_PS   = 4000;
  localparam int REFRESH_MS      = 2;
  localparam int REFRESH_WIN_CYC = (REFRESH_MS * 1000000000) / CLK_PERIOD_PS;
  // Longest spacing rounds down so every row fits inside the window
  localparam int REFRESH_GAP_CYC = REFRESH_WIN_CYC / ROW_COUNT;
  localparam int SETUP_CYC       = 2;
  localparam int STROBE_CYC      = 4;
  localparam int PRECHARGE_CYC   = 3;

  // ==========================================================
  // Request carrier from the user side
  typedef struct packed {
    logic              write;
    logic [ADDR_W-1:0] addr;
    logic              data;
  } dram_req_t;

  // Pins toward the memory chips
  typedef struct packed {
    logic             row_strobe;
    logic             col_strobe;
    logic             write_en;
    logic [ROW_W-1:0] addr;
    logic             data;
  } dram_pins_t;

endpackage

//--- src/dram_ctrl.sv
// Controller that drives a 16K x 1 dynamic RAM through its strobe pins
//
// Function
// - 14-bit address sent as two halves
// - Row half presented, then row strobe asserted
// - Column half then column strobe follows
// - Write uses same sequence, write asserted
// - All 128 rows refreshed every 2 ms
// - Transfers marked by handshake, not timing
// - Requester waits for each module's completion
// - Refresh beats user request on conflict
`timescale 1ns/1ps
`default_nettype none

module dram_ctrl
  import dram_ctrl_pkg::*;
#(
  parameter int REFRESH_GAP = REFRESH_GAP_CYC
)
(
  input  wire logic                      i_clk,
  input  wire logic                      i_srst,
  input  wire logic                      i_req_valid,
  input  wire dram_ctrl_pkg::dram_req_t  i_req,
  output logic                           o_req_ready,
  output logic                           o_rsp_valid,
  output logic                           o_rsp_data,
  output logic                           o_refresh_active,
  output dram_ctrl_pkg::dram_pins_t      o_pins,
  input  wire logic                      i_dout
);
  import dram_ctrl_pkg::*;

  // ==========================================================
  // States
  typedef enum logic [6:0] {
    ST_IDLE  = 7'b0000001,
    ST_RSET  = 7'b0000010,
    ST_RAS   = 7'b0000100,
    ST_CSET  = 7'b0001000,
    ST_CAS   = 7'b0010000,
    ST_PRE   = 7'b0100000,
    ST_DONE  = 7'b1000000
  } state_t;

  localparam int CNT_W = 32;

  state_t           state;
  state_t           next_state;
  logic [CNT_W-1:0] timer;
  logic [CNT_W-1:0] next_timer;
  logic [CNT_W-1:0] ref_cnt;
  logic [CNT_W-1:0] next_ref_cnt;
  logic             ref_pend;
  logic             next_ref_pend;
  logic             is_refresh;
  logic             next_is_refresh;
  logic [ROW_W-1:0] ref_row;
  logic [ROW_W-1:0] next_ref_row;
  dram_req_t        cur;
  dram_req_t        next_cur;
  dram_pins_t       pins;
  dram_pins_t       next_pins;
  logic             rsp_v;
  logic             next_rsp_v;
  logic             rsp_d;
  logic             next_rsp_d;
  logic             dout_meta;
  logic             dout_sync;

  // ==========================================================
  // Pin input synchroniser; the chip is clockless to us
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      dout_meta <= 1'b0;
      dout_sync <= 1'b0;
    end
    else
    begin
      dout_meta <= i_dout;
      dout_sync <= dout_meta;
    end
  end

  // Row half and column half of a full address
  function automatic logic [ROW_W-1:0] row_of(input logic [ADDR_W-1:0] a);
    row_of = a[ADDR_W-1:ROW_LSB];
  endfunction

  function automatic logic [COL_W-1:0] col_of(input logic [ADDR_W-1:0] a);
    col_of = a[COL_W-1:0];
  endfunction

  // ==========================================================
  // Sequencer: next state
  always_comb
  begin
    next_state      = state;
    next_timer      = timer;
    next_ref_pend   = ref_pend;
    next_is_refresh = is_refresh;
    next_ref_row    = ref_row;
    next_cur        = cur;
    next_pins       = pins;
    next_rsp_v      = 1'b0;
    next_rsp_d      = rsp_d;
    // Refresh interval timer; the pending flag set wins over its clear
    if (ref_cnt >= CNT_W'(REFRESH_GAP - 1))
    begin
      next_ref_cnt  = '0;
      next_ref_pend = 1'b1;
    end
    else
    begin
      next_ref_cnt = ref_cnt + CNT_W'(1);
    end
    if (timer != '0)
    begin
      next_timer = timer - CNT_W'(1);
    end
    case (state)
      ST_IDLE:
      begin
        // Refresh first, user access only when none is owed
        if (ref_pend)
        begin
          next_is_refresh = 1'b1;
          if (!(ref_cnt >= CNT_W'(REFRESH_GAP - 1)))
          begin
            next_ref_pend = 1'b0;
          end
          next_pins.addr  = ref_row;
          next_timer      = CNT_W'(SETUP_CYC - 1);
          next_state      = ST_RSET;
        end
        else if (i_req_valid)
        begin
          next_is_refresh   = 1'b0;
          next_cur          = i_req;
          next_pins.addr    = row_of(i_req.addr);
          next_pins.write_en = i_req.write;
          next_pins.data    = i_req.data;
          next_timer        = CNT_W'(SETUP_CYC - 1);
          next_state        = ST_RSET;
        end
      end
      ST_RSET:
      begin
        // Address held a setup time before the strobe rises
        if (timer == '0)
        begin
          next_pins.row_strobe = 1'b1;
          next_timer           = CNT_W'(STROBE_CYC - 1);
          next_state           = ST_RAS;
        end
      end
      ST_RAS:
      begin
        if (timer == '0)
        begin
          if (is_refresh)
          begin
            // Row phase only, no column strobe
            next_pins.row_strobe = 1'b0;
            next_ref_row         = ref_row + ROW_W'(1);
            next_timer           = CNT_W'(PRECHARGE_CYC - 1);
            next_state           = ST_PRE;
          end
          else
          begin
            next_pins.addr = col_of(cur.addr);
            next_timer     = CNT_W'(SETUP_CYC - 1);
            next_state     = ST_CSET;
          end
        end
      end
      ST_CSET:
      begin
        if (timer == '0)
        begin
          next_pins.col_strobe = 1'b1;
          next_timer           = CNT_W'(STROBE_CYC - 1);
          next_state           = ST_CAS;
        end
      end
      ST_CAS:
      begin
        // Data captured at the end so the synchroniser has settled
        if (timer == '0)
        begin
          next_rsp_d           = dout_sync;
          next_pins.col_strobe = 1'b0;
          next_pins.row_strobe = 1'b0;
          next_pins.write_en   = 1'b0;
          next_timer           = CNT_W'(PRECHARGE_CYC - 1);
          next_state           = ST_PRE;
        end
      end
      ST_PRE:
      begin
        if (timer == '0)
        begin
          next_state = ST_DONE;
        end
      end
      ST_DONE:
      begin
        // Completion handshake; requester waits for it
        next_rsp_v = !is_refresh;
        next_state = ST_IDLE;
      end
      default:
      begin
        next_state = ST_IDLE;
      end
    endcase
  end

  // ==========================================================
  // Sequencer registers
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      state      <= ST_IDLE;
      timer      <= '0;
      ref_cnt    <= '0;
      ref_pend   <= 1'b0;
      is_refresh <= 1'b0;
      ref_row    <= '0;
      cur        <= '0;
      pins       <= '0;
      rsp_v      <= 1'b0;
      rsp_d      <= 1'b0;
    end
    else
    begin
      state      <= next_state;
      timer      <= next_timer;
      ref_cnt    <= next_ref_cnt;
      ref_pend   <= next_ref_pend;
      is_refresh <= next_is_refresh;
      ref_row    <= next_ref_row;
      cur        <= next_cur;
      pins       <= next_pins;
      rsp_v      <= next_rsp_v;
      rsp_d      <= next_rsp_d;
    end
  end

  // ==========================================================
  // Outputs
  assign o_req_ready      = (state == ST_IDLE) && !ref_pend;
  assign o_rsp_valid      = rsp_v;
  assign o_rsp_data       = rsp_d;
  assign o_refresh_active = is_refresh && (state != ST_IDLE);
  assign o_pins           = pins;

endmodule

`default_nettype wire

//--- tb/dram_ctrl_checker.sv
// Checker: strobe timing and handshake at the controller ports
`timescale 1ns/1ps
`default_nettype none
module dram_ctrl_checker
  import dram_ctrl_pkg::*;
#(
  parameter int REFRESH_GAP = REFRESH_GAP_CYC
)
(
  input wire logic                      i_clk,
  input wire logic                      i_srst,
  input wire logic                      i_req_valid,
  input wire dram_ctrl_pkg::dram_req_t  i_req,
  input wire logic                      o_req_ready,
  input wire logic                      o_rsp_valid,
  input wire logic                      o_rsp_data,
  input wire logic                      o_refresh_active,
  input wire dram_ctrl_pkg::dram_pins_t o_pins,
  input wire logic                      i_dout
);
  int        gap;
  int        since;
  wire logic tk = i_req_valid && o_req_ready;
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_srst);
  // ==========================================================
  // Cycles since a refresh began; one access may delay the next
  always_ff @(posedge i_clk)
    gap <= (i_srst || $rose(o_refresh_active)) ? 0 : gap + 1;
  // Cycles since the last take; a counter instead of a long repetition
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
      since <= 0;
    else if (tk)
      since <= 1;
    else if (since != 0 && !o_rsp_valid)
      since <= since + 1;
    else
      since <= 0;
  end
  a_row_half: assert property (tk |=> o_pins.addr == $past(i_req.addr[13:7]))
    else $error("row half wrong");
  a_row_strobe: assert property (tk |-> ##3 o_pins.row_strobe && !o_pins.col_strobe)
    else $error("row strobe late");
  a_col_half: assert property (tk |-> ##7 o_pins.addr == $past(i_req.addr[6:0], 7))
    else $error("column half wrong");
  a_col_strobe: assert property (tk |-> ##9 o_pins.col_strobe && o_pins.row_strobe)
    else $error("column strobe late");
  a_write_level: assert property (tk |=> o_pins.write_en == $past(i_req.write))
    else $error("write level wrong");
  a_answer_time: assert property (tk |-> ##17 o_rsp_valid)
    else $error("answer not at cycle 17");
  a_answer_early: assert property (o_rsp_valid |-> since == 17)
    else $error("answer before cycle 17");
  a_refresh_only: assert property (o_refresh_active |-> !o_pins.col_strobe && !o_req_ready)
    else $error("column strobe in refresh");
  a_row_stable: assert property ($rose(o_pins.row_strobe) |-> $stable(o_pins.addr) [*4])
    else $error("row half moved");
  a_col_stable: assert property ($rose(o_pins.col_strobe) |-> $stable(o_pins.addr) [*4])
    else $error("column half moved");
  a_refresh_due: assert property (gap <= REFRESH_GAP + 20)
    else $error("refresh overdue");
endmodule
`default_nettype wire

//--- tb/dram_chip_model.sv
// Behavioural 16K x 1 dynamic RAM chip facing the controller pins
`timescale 1ns/1ps
`default_nettype none
module dram_chip_model
  import dram_ctrl_pkg::*;
(
  input  wire dram_ctrl_pkg::dram_pins_t i_pins,
  input  wire logic                      i_clr,
  output logic                           o_dout,
  output logic [ROW_COUNT-1:0]           o_seen,
  output logic [15:0]                    o_order_err
);
  logic             cells [ROW_COUNT*ROW_COUNT];
  logic [ROW_W-1:0] row;
  logic [ROW_W-1:0] last = 7'h7F;
  logic             col_hit = 1'b0;
  wire logic        ras = i_pins.row_strobe;
  wire logic        cas = i_pins.col_strobe;
  // ==========================================================
  // No clock: the strobe edges run the chip
  initial
  begin
    o_dout = 1'b0;
    o_seen = '0;
    o_order_err = '0;
  end
  always @(posedge ras)
    row = i_pins.addr;
  // Store first on write, then show the amplifier bit
  always @(posedge cas)
  begin
    col_hit = 1'b1;
    if (i_pins.write_en)
      cells[{row, i_pins.addr}] = i_pins.data;
    o_dout = cells[{row, i_pins.addr}];
  end
  // Released output shows the inverse, never a stale bit
  always @(negedge cas)
    o_dout = ~o_dout;
  // Row phase alone is a refresh; rows must come in order
  always @(negedge ras)
  begin
    if (!col_hit)
    begin
      o_seen[row] = 1'b1;
      if (row !== last + 7'h01)
        o_order_err++;
      last = row;
    end
    col_hit = 1'b0;
  end
  always @(posedge i_clr)
    o_seen = '0;
endmodule
`default_nettype wire

//--- tb/dram_array_access_refresh_tb_top.sv
// Testbench: controller against a behavioural memory chip
`timescale 1ns/1ps
`default_nettype none
module dram_array_access_refresh_tb_top;
  import dram_ctrl_pkg::*;
  localparam int GAP = 40;
  logic         clk, srst, vld, ready, rsp_v, rsp_d, ref_act, dout, clr;
  dram_req_t    req;
  dram_pins_t   pins;
  logic [127:0] seen;
  logic [15:0]  order_err;
  int           bad_count, checks;
  dram_ctrl #(.REFRESH_GAP(GAP)) dut (.i_clk(clk), .i_srst(srst), .i_req_valid(vld),
    .i_req(req), .o_req_ready(ready), .o_rsp_valid(rsp_v), .o_rsp_data(rsp_d),
    .o_refresh_active(ref_act), .o_pins(pins), .i_dout(dout));
  dram_chip_model chip (.i_pins(pins), .i_clr(clr), .o_dout(dout), .o_seen(seen),
    .o_order_err(order_err));
  // ==========================================================
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    checks++;
    if (g !== e)
    begin
      bad_count++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic give_verdict();
    if (bad_count == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // One access: hold the request until taken, then wait for the answer
  task automatic acc(input logic w, input logic [13:0] a, input logic d, output logic r);
    int n;
    req = '{write: w, addr: a, data: d};
    vld = 1'b1;
    for (n = 0; ready !== 1'b1 && n < 500; n++)
      @(posedge clk) #1;
    chk(ready, 1'b1);
    @(posedge clk) #1;
    vld = 1'b0;
    for (n = 0; rsp_v !== 1'b1 && n < 50; n++)
      @(posedge clk) #1;
    chk(16'(n), 16'h0010);
    r = rsp_d;
  endtask
  // Corner addresses, back to back, written twice with flipped data
  task automatic t_rw();
    logic [13:0] a [6] = '{14'h0000, 14'h3FFF, 14'h2A55, 14'h15AA, 14'h007F, 14'h3F80};
    logic        r;
    for (int p = 0; p < 2; p++)
    begin
      foreach (a[i])
        acc(1'b1, a[i], i[0] ^ p[0], r);
      foreach (a[i])
      begin
        acc(1'b0, a[i], 1'b0, r);
        chk(r, i[0] ^ p[0]);
      end
    end
  endtask
  // Idle long enough for every row to be refreshed once
  task automatic t_refresh();
    clr = 1'b1;
    @(posedge clk) #1;
    clr = 1'b0;
    repeat (128 * GAP + 200) @(posedge clk);
    #1;
    chk(seen === '1, 1'b1);
    chk(order_err, 16'h0000);
  endtask
  // ==========================================================
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial
  begin
    #80000;
    bad_count++;
    give_verdict();
  end
  initial
  begin
    srst = 1'b1;
    vld = 1'b0;
    req = '0;
    clr = 1'b0;
    repeat (6) @(posedge clk);
    #1;
    chk(pins, '0);
    srst = 1'b0;
    t_rw();
    t_refresh();
    give_verdict();
  end
endmodule
bind dram_ctrl dram_ctrl_checker #(.REFRESH_GAP(REFRESH_GAP)) chk_i (.i_clk(i_clk),
  .i_srst(i_srst), .i_req_valid(i_req_valid), .i_req(i_req), .o_req_ready(o_req_ready),
  .o_rsp_valid(o_rsp_valid), .o_rsp_data(o_rsp_data), .o_refresh_active(o_refresh_active),
  .o_pins(o_pins), .i_dout(i_dout));
`default_nettype wire
